// File: bench/ffx_host_model.sv
// Writing and reading host model that drives the FIFO's pins.
// Assumes the system clock samples every pin; link clocks run 200 ns.
`timescale 1ns/1ps
`default_nettype none
module ffx_host_model import ffx_pkg::*; (
	input  wire logic i_clk_sys,          // System clock
	output logic      o_wr_clk,           // Write clock pin
	output logic      o_rd_clk,           // Read clock pin
	output logic      o_write_enable_n,   // Write enable
	output ffx_word_t o_write_data,       // Write data
	output logic      o_read_enable_n,    // Read enable
	output logic      o_retransmit_req_n  // Retransmit request
);
	// Idle pins; clocks stand still between transfers
	initial begin
		o_wr_clk = 1'h0;
		o_rd_clk = 1'h0;
		o_write_enable_n = 1'h1;
		o_write_data = '0;
		o_read_enable_n = 1'h1;
		o_retransmit_req_n = 1'h1;
	end
	// Four system cycles make half of the 200 ns link period
	task automatic half();
		repeat (4) @(posedge i_clk_sys);
	endtask
	// One write period; data held well past the rise for the synchronisers
	task automatic put(input ffx_word_t d);
		@(posedge i_clk_sys);
		o_write_enable_n <= 1'h0;
		o_write_data <= d;
		half();
		o_wr_clk <= 1'h1;
		half();
		o_wr_clk <= 1'h0;
		o_write_enable_n <= 1'h1;
		o_write_data <= ~d; // Released bus must not keep the last word
	endtask
	// One read period; rt asks for a retransmit instead of a read
	task automatic pulse(input logic en, input logic rt);
		@(posedge i_clk_sys);
		o_read_enable_n <= ~en;
		o_retransmit_req_n <= ~rt;
		half();
		o_rd_clk <= 1'h1;
		half();
		o_rd_clk <= 1'h0;
		o_read_enable_n <= 1'h1;
		o_retransmit_req_n <= 1'h1;
	endtask
endmodule
`default_nettype wire

// File: bench/ffx_tb.sv
// Self-checking bench for the FIFO flag, echo and retransmit block.
// Assumes the design sources and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ffx_pkg::*;
	logic       clk = 1'h0;    // System clock
	logic       rst = 1'h1;    // Master reset
	logic       sel_n = 1'h0;  // Read select
	logic       oe_n = 1'h0;   // Output enable
	logic       mark_n = 1'h1; // Mark
	logic       prst_n = 1'h1; // Partial reset
	logic       flag_timing_select = 1'h1;    // Flag timing select
	logic       fall_through_mode = 1'h0;   // Fall-through mode
	logic       ard = 1'h0;    // Async read
	ffx_count_t ae_off = '0;   // Almost-empty offset
	ffx_count_t af_off = '0;   // Almost-full offset
	logic       wclk, rclk, wen_n, ren_n, rt_n, q_oe;
	logic       empty_n, valid_n, full_n, ready_n, ae_n, af_n, hfull_n, echo_n;
	ffx_word_t  wdata, q;
	int         seed = 36;
	int         fails = 0;
	int         check_count = 0;
	int         cycles = 0;
	int         mx = 32;
	int         cap = 32;
	ffx_word_t  model_q[$];
	ffx_word_t  mark_q[$];

	// 40 MHz system clock
	always #12.5 clk = ~clk;

	ffx_host_model ffx_host_model_inst (.i_clk_sys(clk), .o_wr_clk(wclk), .o_rd_clk(rclk),
		.o_write_enable_n(wen_n), .o_write_data(wdata), .o_read_enable_n(ren_n),
		.o_retransmit_req_n(rt_n));

	ffx_flags ffx_flags_inst (.i_clk_sys(clk), .i_reset(rst), .i_wr_clk(wclk),
		.i_rd_clk(rclk), .i_write_enable_n(wen_n), .i_write_data(wdata),
		.i_read_enable_n(ren_n), .i_read_select_n(sel_n), .i_output_enable_n(oe_n),
		.i_retransmit_req_n(rt_n), .i_mark_n(mark_n), .i_partial_reset_n(prst_n),
		.i_flag_timing_select(flag_timing_select), .i_fall_through_mode(fall_through_mode), .i_async_read(ard),
		.i_ae_offset(ae_off), .i_af_offset(af_off), .o_output_data_bus(q),
		.o_output_data_oe(q_oe), .o_empty_flag_n(empty_n), .o_output_valid_n(valid_n),
		.o_full_flag_n(full_n), .o_input_ready_n(ready_n), .o_almost_empty_flag_n(ae_n),
		.o_almost_full_flag_n(af_n), .o_half_full_n(hfull_n),
		.o_read_enable_echo_n(echo_n));

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Cycle ceiling; the four runs need well under five thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			$display("MISMATCH at %0t: timeout", $time);
			final_report();
		end
	end

	// One comparison point so every mismatch is counted alike
	task automatic check(input logic [71:0] got, input logic [71:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	// Let the design's edge updates land before sampling
	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	// Expected {full, ready, almost-full, half, almost-empty} for a fill level
	function automatic logic [4:0] exp_flags(input int fill);
		exp_flags[4] = fall_through_mode | (fill < cap);
		exp_flags[3] = fall_through_mode & (fill >= cap);
		exp_flags[2] = !(fill >= mx - int'(af_off));
		exp_flags[1] = !(fill > mx / 2);
		exp_flags[0] = !(fill <= int'(ae_off));
	endfunction

	// Reset with new modes and random offsets, then the idle flag values
	task automatic do_reset(input logic t_pfm, input logic t_ft, input logic t_ard);
		@(posedge clk);
		rst <= 1'h1;
		flag_timing_select <= t_pfm;
		fall_through_mode <= t_ft;
		ard <= t_ard;
		ae_off <= 6'h02 + 6'({$random(seed)} % 6);
		af_off <= 6'h02 + 6'({$random(seed)} % 6);
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		settle();
		model_q.delete();
		check({empty_n, valid_n, full_n, ready_n, ae_n, af_n, hfull_n, echo_n}, 8'h67, "idle");
	endtask

	// Random word from the host; the model drops it when no room is left
	task automatic wr();
		ffx_word_t  d;
		logic [4:0] f;
		d = {8'($random(seed)), $random(seed), $random(seed)};
		ffx_host_model_inst.put(d);
		if (model_q.size() < cap) begin
			model_q.push_back(d);
		end
		settle();
		f = exp_flags(model_q.size());
		check(full_n, f[4], "full");
		check(ready_n, f[3], "ready");
		check(af_n, f[2], "almost full");
		check(hfull_n, f[1], "half full");
		if (!flag_timing_select) begin
			check(ae_n, f[0], "almost empty");
		end
	endtask

	// Standard read: data, echo, drive and flags
	task automatic pop();
		ffx_word_t  e;
		logic       had;
		logic       af_was;
		logic [4:0] f;
		had = model_q.size() > 0;
		af_was = af_n;
		if (had) begin
			e = model_q.pop_front();
		end
		ffx_host_model_inst.pulse(1'h1, 1'h0);
		settle();
		f = exp_flags(model_q.size());
		check(echo_n, !had, "echo");
		if (had) begin
			check(q, e, "data");
		end
		check(q_oe, 1'h1, "bus drive");
		check(empty_n, model_q.size() > 0, "empty");
		check(ae_n, f[0], "almost empty");
		check(hfull_n, f[1], "half full");
		check(af_n, flag_timing_select ? af_was : f[2], "almost full");
	endtask

	// Fill past full with reads stalled, a deselected read, then drain
	task automatic fill_drain();
		repeat (mx + 1) wr();
		@(posedge clk);
		sel_n <= 1'h1;
		ffx_host_model_inst.pulse(1'h1, 1'h0);
		settle();
		check(q_oe, 1'h0, "bus off");
		check(echo_n, 1'h1, "echo deselected");
		@(posedge clk);
		sel_n <= 1'h0;
		repeat (mx + 1) pop();
	endtask

	// Mark, rewind, replay, then writes held back by the mark
	task automatic retransmit();
		int n;
		repeat (20) wr();
		repeat (2) pop();
		@(posedge clk);
		mark_n <= 1'h0;
		ffx_host_model_inst.pulse(1'h0, 1'h0);
		mark_q = model_q;
		repeat (3) pop();
		ffx_host_model_inst.pulse(1'h0, 1'h1);
		settle();
		check(empty_n, 1'h0, "setup empty");
		n = 0;
		while (empty_n !== 1'h1 && n < 4) begin
			ffx_host_model_inst.pulse(1'h0, 1'h0);
			settle();
			n++;
		end
		check(empty_n, 1'h1, "setup done");
		model_q = mark_q;
		repeat (18) pop();
		cap = 14;
		repeat (16) wr();
		cap = mx;
		@(posedge clk);
		mark_n <= 1'h1;
		ffx_host_model_inst.pulse(1'h0, 1'h0);
		repeat (15) pop();
	endtask

	// Fall-through loads, echo pulses and the last-word read
	task automatic fall_through();
		@(posedge clk);
		sel_n <= 1'h1;
		repeat (3) wr();
		ffx_host_model_inst.pulse(1'h0, 1'h0);
		settle();
		check({valid_n, echo_n, q_oe}, 3'h0, "first load");
		ffx_host_model_inst.pulse(1'h0, 1'h0);
		settle();
		check(echo_n, 1'h1, "no load");
		@(posedge clk);
		sel_n <= 1'h0;
		settle();
		check(q, model_q[0], "first word");
		repeat (3) begin
			void'(model_q.pop_front());
			ffx_host_model_inst.pulse(1'h1, 1'h0);
			settle();
			check({valid_n, echo_n}, {2{model_q.size() == 0}}, "read");
			if (model_q.size() > 0) begin
				check(q, model_q[0], "next word");
			end
		end
		wr();
		ffx_host_model_inst.pulse(1'h0, 1'h0);
		repeat (mx) wr();
	endtask

	// Standard mode, asynchronous read: the enable release pops, so wait past it
	task automatic async_read();
		ffx_word_t e;
		repeat (2) wr();
		e = model_q.pop_front();
		ffx_host_model_inst.pulse(1'h1, 1'h0);
		repeat (2) @(posedge clk);
		settle();
		check(q, e, "async data");
	endtask

	// Runs: sync standard, async flags, async read, fall-through with async read set
	initial begin
		do_reset(1'h1, 1'h0, 1'h0);
		fill_drain();
		retransmit();
		repeat (3) wr();
		@(posedge clk);
		prst_n <= 1'h0;
		repeat (4) @(posedge clk);
		prst_n <= 1'h1;
		settle();
		model_q.delete();
		check({empty_n, ae_n}, 2'h0, "partial reset");
		wr();
		$display("Test sync standard done");
		do_reset(1'h0, 1'h0, 1'h0);
		fill_drain();
		$display("Test async flags done");
		do_reset(1'h1, 1'h0, 1'h1);
		async_read();
		$display("Test async read done");
		mx = 33;
		cap = 33;
		do_reset(1'h1, 1'h1, 1'h1);
		fall_through();
		$display("Test fall-through done");
		final_report();
	end
endmodule
`default_nettype wire

// File: core/ffx_defines.svh
// Constants for the flag and retransmit logic of the 72-bit FIFO.
// Included by the package and the flag block; definitions only.
`ifndef FFX_DEFINES_SVH
`define FFX_DEFINES_SVH
`define FFX_DW       72
`define FFX_DEPTH    32
`define FFX_AW       5
`define FFX_CW       6
`define FFX_TW       7
`define FFX_DEPTH_T  7'h20
`define FFX_FT_EXTRA 7'h01
`define FFX_RT_SETUP 2'h2
`define FFX_PIN_W    12
// Positions inside the synchronised control pin vector
`define FFX_P_WCLK   0
`define FFX_P_RCLK   1
`define FFX_P_WEN    2
`define FFX_P_REN    3
`define FFX_P_RCS    4
`define FFX_P_OE     5
`define FFX_P_RT     6
`define FFX_P_MARK   7
`define FFX_P_PRS    8
`define FFX_P_PFM    9
`define FFX_P_FALL_THROUGH_MODE   10
`define FFX_P_ARD    11
`endif

// File: core/ffx_fifo.sv
// Word storage with mark and rewind, flip-flop array indexed by pointer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ffx_fifo import ffx_pkg::*; #(
	parameter int WIDTH = `FFX_DW,
	parameter int DEPTH = `FFX_DEPTH
) (
	input  wire logic i_clk_sys, // System clock
	input  wire logic i_reset,   // Synchronous reset
	ffx_fifo_if.store f          // Control side
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wptr_r, rptr_r, mark_r;
	logic             marked_r;
	logic [AW:0]      base, used;

	// While marked, the region back to the mark is protected from overwrite
	assign base       = marked_r ? mark_r : rptr_r;
	assign used       = wptr_r - base;
	assign f.wr_ready = (used != (AW+1)'(DEPTH));
	assign f.rd_valid = (wptr_r != rptr_r);
	assign f.rd_data  = mem_r[rptr_r[AW-1:0]];
	assign f.count    = `FFX_CW'(wptr_r - rptr_r);

	// Write pointer and storage
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || f.clr) begin
			wptr_r <= '0;
		end else if (f.wr_valid && f.wr_ready) begin
			mem_r[wptr_r[AW-1:0]] <= f.wr_data;
			wptr_r <= wptr_r + 1'b1;
		end
	end

	// Read pointer; rewind reloads it from the captured mark
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || f.clr) begin
			rptr_r <= '0;
		end else if (f.rewind && marked_r) begin
			rptr_r <= mark_r;
		end else if (f.rd_ready && f.rd_valid) begin
			rptr_r <= rptr_r + 1'b1;
		end
	end

	// Mark capture of the read pointer
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || f.clr || f.mark_clr) begin
			marked_r <= 1'b0;
			mark_r   <= '0;
		end else if (f.mark_set && !marked_r) begin
			marked_r <= 1'b1;
			mark_r   <= rptr_r;
		end
	end

	mark_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		marked_r && used == (AW+1)'(DEPTH) && f.wr_valid |=> $stable(wptr_r))
		else $error("write passed the mark");
endmodule
`default_nettype wire

// File: core/ffx_fifo_if.sv
// Carrier between the flag logic and the word storage.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface ffx_fifo_if;
	import ffx_pkg::*;
	logic       wr_valid;
	logic       wr_ready;
	ffx_word_t  wr_data;
	logic       rd_valid;
	logic       rd_ready;
	ffx_word_t  rd_data;
	logic       mark_set;
	logic       mark_clr;
	logic       rewind;
	logic       clr;
	ffx_count_t count;
	modport ctrl (output wr_valid, wr_data, rd_ready, mark_set, mark_clr, rewind, clr,
		input wr_ready, rd_valid, rd_data, count);
	modport store (input wr_valid, wr_data, rd_ready, mark_set, mark_clr, rewind, clr,
		output wr_ready, rd_valid, rd_data, count);
endinterface
`default_nettype wire

// File: core/ffx_flags.sv
// Read side, flags, echo and retransmit of a 72-bit dual-clock FIFO.
// Assumes write and read clocks arrive as pins, sampled by i_clk_sys.
// How it works
// - Empty flag returns high only when retransmit setup is finished.
// - With a mark set, the write pointer never passes the marked location.
// - Almost-empty may change one read edge early during retransmit.
// - Flag depth is nominal in standard mode, one more in fall-through.
// - Almost-full release may slip one write edge on close clock skew.
// - Almost-empty release may slip one read edge on close clock skew.
// - Synchronous almost-full updates on write clock edges only.
// - Timing select caught at master reset picks sync or async flags.
// - Async almost-full falls on write edges, rises on read edges.
// - Async almost-empty falls on read edges, rises on write edges.
// - In standard mode, read enable echo follows select and enable, forced high when empty.
// - Read enable echo changes only on read clock edges.
// - Output bus driven only while select and output enable are low.
// - In fall-through, a load drops output-valid and pulses the echo low.
// - Enabled read after the last word raises output-valid and echo.
// - Asynchronous read works only in standard mode.
`timescale 1ns/1ps
`default_nettype none
`include "ffx_defines.svh"
module ffx_flags import ffx_pkg::*; (
	input  wire logic              i_clk_sys,              // 40 MHz system clock
	input  wire logic              i_reset,                // Master reset, active high
	input  wire logic              i_wr_clk,               // Write clock pin
	input  wire logic              i_rd_clk,               // Read clock pin
	input  wire logic              i_write_enable_n,       // Write enable, low active
	input  wire logic [`FFX_DW-1:0] i_write_data,          // Write data pins
	input  wire logic              i_read_enable_n,        // Read enable, low active
	input  wire logic              i_read_select_n,        // Read chip select
	input  wire logic              i_output_enable_n,      // Output enable
	input  wire logic              i_retransmit_req_n,     // Retransmit request
	input  wire logic              i_mark_n,               // Mark, held low to keep
	input  wire logic              i_partial_reset_n,      // Partial reset
	input  wire logic              i_flag_timing_select,   // High: synchronous flags
	input  wire logic              i_fall_through_mode,    // High: fall-through timing
	input  wire logic              i_async_read,           // High: asynchronous read
	input  wire logic [`FFX_CW-1:0] i_ae_offset,           // Almost-empty offset
	input  wire logic [`FFX_CW-1:0] i_af_offset,           // Almost-full offset
	output logic [`FFX_DW-1:0]     o_output_data_bus,      // Output register
	output logic                   o_output_data_oe,       // Output bus drive enable
	output logic                   o_empty_flag_n,         // Standard empty flag
	output logic                   o_output_valid_n,       // Fall-through valid flag
	output logic                   o_full_flag_n,          // Standard full flag
	output logic                   o_input_ready_n,        // Fall-through ready flag
	output logic                   o_almost_empty_flag_n,  // Almost-empty flag
	output logic                   o_almost_full_flag_n,   // Almost-full flag
	output logic                   o_half_full_n,          // Half-full flag
	output logic                   o_read_enable_echo_n    // Echoed read enable
);
	ffx_fifo_if fi ();
	ffx_fifo #(.WIDTH(`FFX_DW), .DEPTH(`FFX_DEPTH)) u_store (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.f         (fi.store)
	);

	// Two-flop synchronisers; stage one feeds stage two only
	logic [`FFX_PIN_W-1:0] pin_m_r, pin_s_r, pin_q_r;
	ffx_word_t             dat_m_r, dat_s_r;
	always_ff @(posedge i_clk_sys) begin
		pin_m_r <= {i_async_read, i_fall_through_mode, i_flag_timing_select,
			i_partial_reset_n, i_mark_n, i_retransmit_req_n, i_output_enable_n,
			i_read_select_n, i_read_enable_n, i_write_enable_n, i_rd_clk, i_wr_clk};
		pin_s_r <= pin_m_r;
		pin_q_r <= pin_s_r;
		dat_m_r <= i_write_data;
		dat_s_r <= dat_m_r;
	end

	logic wr_edge, rd_edge, ren_n, rcs_n, prs;
	assign wr_edge = pin_s_r[`FFX_P_WCLK] && !pin_q_r[`FFX_P_WCLK];
	assign rd_edge = pin_s_r[`FFX_P_RCLK] && !pin_q_r[`FFX_P_RCLK];
	assign ren_n   = pin_s_r[`FFX_P_REN];
	assign rcs_n   = pin_s_r[`FFX_P_RCS];
	assign prs     = !pin_s_r[`FFX_P_PRS];

	// Modes caught while master reset holds, kept through partial reset
	logic sync_flags_r, fall_through_mode_r, async_rd_r;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			sync_flags_r <= pin_s_r[`FFX_P_PFM];
			fall_through_mode_r       <= pin_s_r[`FFX_P_FALL_THROUGH_MODE];
			async_rd_r   <= pin_s_r[`FFX_P_ARD];
		end
	end

	// Edge pulses delayed one cycle so flags see the updated count
	logic wr_edge_d_r, rd_edge_d_r;
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			wr_edge_d_r <= 1'b0;
			rd_edge_d_r <= 1'b0;
		end else begin
			wr_edge_d_r <= wr_edge;
			rd_edge_d_r <= rd_edge;
		end
	end

	// Write side: full storage refuses, back-pressure shows on the flags
	assign fi.wr_valid = wr_edge && !pin_s_r[`FFX_P_WEN] && !prs;
	assign fi.wr_data  = dat_s_r;
	assign fi.clr      = prs;

	// Retransmit setup sequencer
	ffx_rt_state_t rt_state_r;
	logic [1:0]    rt_cnt_r;
	logic          marked_r, rt_go, rt_busy;
	assign rt_go   = rd_edge && !pin_s_r[`FFX_P_RT] && marked_r && rt_state_r == FFX_RT_IDLE;
	assign rt_busy = (rt_state_r == FFX_RT_SETUP);
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs) begin
			rt_state_r <= FFX_RT_IDLE;
			rt_cnt_r   <= 2'h0;
		end else begin
			case (rt_state_r)
				FFX_RT_IDLE: begin
					if (rt_go) begin
						rt_state_r <= FFX_RT_SETUP;
						rt_cnt_r   <= `FFX_RT_SETUP;
					end
				end
				FFX_RT_SETUP: begin
					if (rd_edge) begin
						rt_cnt_r <= rt_cnt_r - 2'h1;
						if (rt_cnt_r == 2'h1) begin
							rt_state_r <= FFX_RT_IDLE;
						end
					end
				end
				default: rt_state_r <= FFX_RT_IDLE;
			endcase
		end
	end

	// Mark follows the held mark pin, sampled on read edges
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs) begin
			marked_r <= 1'b0;
		end else if (rd_edge) begin
			marked_r <= !pin_s_r[`FFX_P_MARK];
		end
	end
	assign fi.mark_set = rd_edge && !pin_s_r[`FFX_P_MARK] && !rt_busy;
	assign fi.mark_clr = rd_edge && pin_s_r[`FFX_P_MARK];
	assign fi.rewind   = rt_go;

	// Read strobes; async read is an enable pulse end, standard mode only
	logic ovalid_r, async_on, ren_rise, rd_ok, pop, last_out;
	assign async_on = async_rd_r && !fall_through_mode_r;
	assign ren_rise = ren_n && !pin_q_r[`FFX_P_REN];
	assign rd_ok    = !ren_n && !rcs_n;
	always_comb begin
		if (rt_busy || rt_go || prs) begin
			pop = 1'b0;
		end else if (fall_through_mode_r) begin
			pop = rd_edge && fi.rd_valid && (!ovalid_r || rd_ok);
		end else if (async_on) begin
			pop = ren_rise && !rcs_n && fi.rd_valid;
		end else begin
			pop = rd_edge && rd_ok && fi.rd_valid;
		end
	end
	assign fi.rd_ready = pop;
	assign last_out    = fall_through_mode_r && rd_edge && rd_ok && ovalid_r && !fi.rd_valid && !rt_busy;

	// Output register and its valid state
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_output_data_bus <= '0;
		end else if (pop) begin
			o_output_data_bus <= fi.rd_data;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs || rt_go) begin
			ovalid_r <= 1'b0;
		end else if (pop) begin
			ovalid_r <= 1'b1;
		end else if (last_out) begin
			ovalid_r <= 1'b0;
		end
	end

	// Registered valid pin so the output comes from a flop; standard mode holds it high
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs || rt_go || !fall_through_mode_r) begin
			o_output_valid_n <= 1'b1;
		end else if (pop) begin
			o_output_valid_n <= 1'b0;
		end else if (last_out) begin
			o_output_valid_n <= 1'b1;
		end
	end

	// Bus drive needs both select and output enable low
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_output_data_oe <= 1'b0;
		end else begin
			o_output_data_oe <= !rcs_n && !pin_s_r[`FFX_P_OE];
		end
	end

	// Echo: select and enable in standard mode, load marker in fall-through
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs) begin
			o_read_enable_echo_n <= 1'b1;
		end else if (rd_edge) begin
			if (fall_through_mode_r) begin
				o_read_enable_echo_n <= !pop;
			end else begin
				o_read_enable_echo_n <= rcs_n || ren_n || !fi.rd_valid;
			end
		end
	end

	// Fill level seen by the flags; fall-through adds the output word
	logic [`FFX_TW-1:0] fill, max_d;
	logic               af_hit, ae_hit, hf_hit;
	assign fill   = `FFX_TW'(fi.count) + `FFX_TW'(fall_through_mode_r && ovalid_r);
	assign max_d  = fall_through_mode_r ? `FFX_DEPTH_T + `FFX_FT_EXTRA : `FFX_DEPTH_T;
	assign af_hit = fill >= max_d - `FFX_TW'(i_af_offset);
	assign ae_hit = fill <= `FFX_TW'(i_ae_offset);
	assign hf_hit = fill > (max_d >> 1);

	// Empty and full flags; retransmit setup holds empty low
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs || rt_go) begin
			o_empty_flag_n <= 1'b0;
		end else if (rd_edge_d_r && !rt_busy && !fall_through_mode_r) begin
			o_empty_flag_n <= fi.rd_valid;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs) begin
			o_full_flag_n   <= 1'b1;
			o_input_ready_n <= 1'b0;
		end else if (wr_edge_d_r) begin
			o_full_flag_n   <= fall_through_mode_r || fi.wr_ready;
			o_input_ready_n <= fall_through_mode_r ? !fi.wr_ready : 1'b0;
		end
	end

	// Almost-full: sync on write edges only, async falls on write, rises on read
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs) begin
			o_almost_full_flag_n <= 1'b1;
		end else if (sync_flags_r) begin
			if (wr_edge_d_r) begin
				o_almost_full_flag_n <= !af_hit;
			end
		end else if (wr_edge_d_r && af_hit) begin
			o_almost_full_flag_n <= 1'b0;
		end else if (rd_edge_d_r && !af_hit) begin
			o_almost_full_flag_n <= 1'b1;
		end
	end

	// Almost-empty: sync on read edges, async falls on read, rises on write
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs) begin
			o_almost_empty_flag_n <= 1'b0;
		end else if (sync_flags_r) begin
			if (rd_edge_d_r || rt_go) begin
				o_almost_empty_flag_n <= !ae_hit;
			end
		end else if (rd_edge_d_r && ae_hit) begin
			o_almost_empty_flag_n <= 1'b0;
		end else if (wr_edge_d_r && !ae_hit) begin
			o_almost_empty_flag_n <= 1'b1;
		end
	end

	// Half-full follows either clock edge
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || prs) begin
			o_half_full_n <= 1'b1;
		end else if (wr_edge_d_r || rd_edge_d_r) begin
			o_half_full_n <= !hf_hit;
		end
	end

	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset || prs);

	rt_empty_low_a: assert property (rt_go |=> !o_empty_flag_n throughout rt_busy[*2])
		else $error("empty flag rose during retransmit setup");
	echo_std_a: assert property (!fall_through_mode_r && rd_edge && (rcs_n || ren_n) |=> o_read_enable_echo_n)
		else $error("echo low without select and enable");
	echo_edge_a: assert property ($changed(o_read_enable_echo_n) |-> $past(rd_edge))
		else $error("echo moved off a read edge");
	bus_gate_a: assert property (o_output_data_oe |-> $past(!rcs_n && !pin_s_r[`FFX_P_OE]))
		else $error("bus driven without select and enable");
	ft_load_a: assert property (fall_through_mode_r && pop |=> !o_read_enable_echo_n && ovalid_r)
		else $error("load did not pulse echo");
	ft_last_a: assert property (last_out |=> o_read_enable_echo_n && o_output_valid_n)
		else $error("last read did not raise flags");
	paf_sync_a: assert property (sync_flags_r && $changed(o_almost_full_flag_n) |-> $past(wr_edge_d_r))
		else $error("almost-full moved off a write edge");
	paf_async_a: assert property (!sync_flags_r && $fell(o_almost_full_flag_n) |-> $past(wr_edge_d_r))
		else $error("almost-full fell off a write edge");
	pae_async_a: assert property (!sync_flags_r && $rose(o_almost_empty_flag_n) |-> $past(wr_edge_d_r))
		else $error("almost-empty rose off a write edge");
	ft_no_async_a: assert property (fall_through_mode_r && ren_rise && !rd_edge |-> !pop)
		else $error("asynchronous read in fall-through");

	// Flag movement tied to the clock edge that may cause it
	hf_edge_a: assert property ($changed(o_half_full_n) |-> $past(wr_edge_d_r || rd_edge_d_r))
		else $error("half-full moved off a clock edge");
	pae_sync_a: assert property (sync_flags_r && $changed(o_almost_empty_flag_n) |-> $past(rd_edge_d_r || rt_go))
		else $error("almost-empty moved off a read edge");
	paf_async_rise_a: assert property (!sync_flags_r && $rose(o_almost_full_flag_n) |-> $past(rd_edge_d_r))
		else $error("almost-full rose off a read edge");
	pae_async_fall_a: assert property (!sync_flags_r && $fell(o_almost_empty_flag_n) |-> $past(rd_edge_d_r))
		else $error("almost-empty fell off a read edge");

	// Echo, valid and setup guards; reads during setup would corrupt the replay
	echo_empty_a: assert property (!fall_through_mode_r && rd_edge && !fi.rd_valid |=> o_read_enable_echo_n)
		else $error("echo low while empty");
	echo_low_a: assert property (!fall_through_mode_r && rd_edge && !rcs_n && !ren_n && fi.rd_valid |=> !o_read_enable_echo_n)
		else $error("echo high on an enabled read");
	valid_track_a: assert property (fall_through_mode_r |-> o_output_valid_n == !ovalid_r)
		else $error("valid pin lost the output word state");
	rt_hold_a: assert property (rt_busy |-> !pop && !fi.mark_set)
		else $error("read or mark during retransmit setup");

	rt_seen_c: cover property (rt_go ##[1:400] $rose(o_empty_flag_n));
	ft_last_c: cover property (last_out);
	af_low_c:  cover property ($fell(o_almost_full_flag_n));
	ft_load_c: cover property (fall_through_mode_r && pop);
	async_pop_c: cover property (async_on && pop);
endmodule
`default_nettype wire

// File: core/ffx_pkg.sv
// Types shared by the FIFO flag block and its storage.
// Assumes ffx_defines.svh sits on the include path.
`include "ffx_defines.svh"
package ffx_pkg;
	typedef enum logic {FFX_RT_IDLE, FFX_RT_SETUP} ffx_rt_state_t;
	typedef logic [`FFX_DW-1:0] ffx_word_t;
	typedef logic [`FFX_CW-1:0] ffx_count_t;
endpackage
